// ===== src/i2ccd_top.sv
// master repeated start / stop sequencer with bus collision detection
`default_nettype none
module i2ccd_top
  import i2ccd_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // register port
  input wire i2ccd_pkg::i2ccd_bus_t BUS,
  output logic [7:0] RDATA,
  // open drain lines, oe low means pull low
  input wire i2ccd_pkg::i2ccd_lines_t LINES,
  output logic SCL_O,
  output logic SCL_OE_N,
  output logic SDA_O,
  output logic SDA_OE_N
);
  import i2ccd_pkg::*;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_RS_REL = 9'h002,
    ST_RS_CNT1 = 9'h004,
    ST_RS_SCLW = 9'h008,
    ST_RS_CNT2 = 9'h010,
    ST_RS_CNT3 = 9'h020,
    ST_P_SDAW = 9'h040,
    ST_P_SCLW = 9'h080,
    ST_P_CNT = 9'h100
  } i2ccd_state_t;

  i2ccd_state_t state_reg, state_next;
  logic scl_s, sda_s, scl_d_reg;
  logic [6:0] cnt_reg, cnt_next;
  logic drv_sda_reg, drv_sda_next, drv_scl_reg, drv_scl_next;
  logic [7:0] buf_reg, add_reg, con1_reg, con2_reg, stat_reg, flags_reg;
  logic coll, seq_done, stop_done;

  i2ccd_sync u_scl
  (
    .clk(MCLK),
    .rst_n(RESETN),
    .d(LINES.scl_in),
    .q(scl_s)
  );
  i2ccd_sync u_sda
  (
    .clk(MCLK),
    .rst_n(RESETN),
    .d(LINES.sda_in),
    .q(sda_s)
  );

  // register decode
  wire wr_buf = BUS.wr && BUS.addr == OFF_BUF;
  wire wr_add = BUS.wr && BUS.addr == OFF_ADD;
  wire wr_con1 = BUS.wr && BUS.addr == OFF_CON1;
  wire wr_con2 = BUS.wr && BUS.addr == OFF_CON2;
  wire wr_flags = BUS.wr && BUS.addr == OFF_FLAGS;
  wire port_en = con1_reg[BIT_EN];
  // counter reload is the low seven bits in master operation
  wire [6:0] reload = add_reg[6:0];
  wire cnt_zero = cnt_reg == CNT_ZERO;
  wire scl_rise = scl_s && !scl_d_reg;
  wire scl_fall = !scl_s && scl_d_reg;
  wire start_rs = port_en && con2_reg[BIT_RESTART_EN]
    && state_reg == ST_IDLE;
  wire start_p = port_en && con2_reg[BIT_STOP_EN]
    && !con2_reg[BIT_RESTART_EN] && state_reg == ST_IDLE;
  wire [7:0] rd_mux =
    (BUS.addr == OFF_BUF) ? buf_reg :
    (BUS.addr == OFF_ADD) ? add_reg :
    (BUS.addr == OFF_CON1) ? (con1_reg & CON1_IMPL) :
    (BUS.addr == OFF_CON2) ? (con2_reg & CON2_IMPL) :
    (BUS.addr == OFF_STAT) ? (stat_reg & STAT_IMPL) :
    (BUS.addr == OFF_FLAGS) ? (flags_reg & FLAGS_IMPL) : RST_BYTE;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_zero ? CNT_ZERO : cnt_reg - 7'h01;
    drv_sda_next = drv_sda_reg;
    drv_scl_next = drv_scl_reg;
    coll = 1'b0;
    seq_done = 1'b0;
    stop_done = 1'b0;
    unique case (state_reg)
      ST_IDLE:
      begin
        // line drive holds: a finished repeated start keeps clock low
        if (start_rs)
        begin
          // release data and hold clock low until it floats
          drv_sda_next = 1'b0;
          drv_scl_next = 1'b1;
          state_next = ST_RS_REL;
        end
        else if (start_p)
        begin
          drv_sda_next = 1'b1;
          drv_scl_next = 1'b1;
          state_next = ST_P_SDAW;
        end
      end
      ST_RS_REL:
        if (sda_s)
        begin
          cnt_next = reload;
          state_next = ST_RS_CNT1;
        end
      ST_RS_CNT1:
        if (cnt_zero)
        begin
          drv_scl_next = 1'b0;
          state_next = ST_RS_SCLW;
        end
      ST_RS_SCLW:
        if (scl_s)
        begin
          if (!sda_s)
            coll = 1'b1;
          else
          begin
            cnt_next = reload;
            state_next = ST_RS_CNT2;
          end
        end
      ST_RS_CNT2:
        if (scl_fall)
          coll = 1'b1;
        else if (cnt_zero && scl_s && sda_s)
        begin
          drv_sda_next = 1'b1;
          cnt_next = reload;
          state_next = ST_RS_CNT3;
        end
        else if (cnt_zero)
        begin
          // data fell early from another start: drive low too
          drv_sda_next = 1'b1;
          cnt_next = reload;
          state_next = ST_RS_CNT3;
        end
      ST_RS_CNT3:
        if (cnt_zero)
        begin
          drv_scl_next = 1'b1;
          seq_done = 1'b1;
          state_next = ST_IDLE;
        end
      ST_P_SDAW:
        if (!sda_s)
        begin
          drv_scl_next = 1'b0;
          state_next = ST_P_SCLW;
        end
      ST_P_SCLW:
        if (scl_s)
        begin
          cnt_next = reload;
          state_next = ST_P_CNT;
        end
      ST_P_CNT:
        if (!scl_s)
          coll = 1'b1;
        else if (cnt_zero && drv_sda_reg)
        begin
          drv_sda_next = 1'b0;
          cnt_next = reload;
        end
        else if (cnt_zero)
        begin
          if (!sda_s)
            coll = 1'b1;
          else
          begin
            stop_done = 1'b1;
            state_next = ST_IDLE;
          end
        end
      default:
        state_next = ST_IDLE;
    endcase
    if (coll)
    begin
      drv_sda_next = 1'b0;
      drv_scl_next = 1'b0;
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= CNT_ZERO;
      drv_sda_reg <= 1'b0;
      drv_scl_reg <= 1'b0;
      scl_d_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      drv_sda_reg <= drv_sda_next;
      drv_scl_reg <= drv_scl_next;
      scl_d_reg <= scl_s;
    end
  end

  // sequence enables: hardware clear on completion or collision
  logic [7:0] con2_next, flags_next, stat_next;
  always_comb
  begin
    con2_next = wr_con2 ? BUS.wdata : con2_reg;
    if (seq_done)
      con2_next[BIT_RESTART_EN] = 1'b0;
    if (stop_done)
      con2_next[BIT_STOP_EN] = 1'b0;
    if (coll)
    begin
      con2_next[BIT_START_EN] = 1'b0;
      con2_next[BIT_RESTART_EN] = 1'b0;
      con2_next[BIT_STOP_EN] = 1'b0;
      con2_next[BIT_ACK_EN] = 1'b0;
    end
    // software writes one to clear, hardware set wins
    flags_next = wr_flags ? (flags_reg & ~BUS.wdata) : flags_reg;
    if (coll)
      flags_next[BIT_COLIF] = 1'b1;
    if (seq_done || stop_done)
      flags_next[BIT_PORTIF] = 1'b1;
    stat_next = stat_reg;
    if (stop_done)
    begin
      stat_next[BIT_P] = 1'b1;
      stat_next[BIT_S] = 1'b0;
    end
    if (seq_done)
    begin
      stat_next[BIT_S] = 1'b1;
      stat_next[BIT_P] = 1'b0;
    end
    if (!port_en)
      stat_next = RST_BYTE;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      buf_reg <= RST_BYTE;
      add_reg <= RST_BYTE;
      con1_reg <= RST_BYTE;
      con2_reg <= RST_BYTE;
      stat_reg <= RST_BYTE;
      flags_reg <= RST_BYTE;
      RDATA <= RST_BYTE;
    end
    else
    begin
      if (wr_buf)
        buf_reg <= BUS.wdata;
      if (wr_add)
        add_reg <= BUS.wdata;
      if (wr_con1)
        con1_reg <= BUS.wdata;
      con2_reg <= con2_next;
      stat_reg <= stat_next;
      flags_reg <= flags_next;
      RDATA <= BUS.rd ? rd_mux : RST_BYTE;
    end
  end

  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE_N = !drv_scl_reg;
  assign SDA_OE_N = !drv_sda_reg;
endmodule
`default_nettype wire

// ===== src/i2ccd_pkg.sv
// package: register map, field positions and types for the collision block
`default_nettype none
package i2ccd_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFF_BUF = 3'h0;
  localparam logic [2:0] OFF_ADD = 3'h1;
  localparam logic [2:0] OFF_CON1 = 3'h2;
  localparam logic [2:0] OFF_CON2 = 3'h3;
  localparam logic [2:0] OFF_STAT = 3'h4;
  localparam logic [2:0] OFF_FLAGS = 3'h5;
  localparam int BIT_START_EN = 0;
  localparam int BIT_RESTART_EN = 1;
  localparam int BIT_STOP_EN = 2;
  localparam int BIT_ACK_EN = 4;
  localparam int BIT_P = 4;
  localparam int BIT_S = 3;
  localparam int BIT_PORTIF = 0;
  localparam int BIT_COLIF = 1;
  localparam int BIT_EN = 5;
  localparam logic [7:0] CON2_IMPL = 8'h16;
  localparam logic [7:0] CON1_IMPL = 8'h3F;
  localparam logic [7:0] STAT_IMPL = 8'h18;
  localparam logic [7:0] FLAGS_IMPL = 8'h03;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] CNT_ZERO = 7'h00;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } i2ccd_bus_t;
  typedef struct packed {
    logic scl_in;
    logic sda_in;
  } i2ccd_lines_t;
endpackage
`default_nettype wire

// ===== src/i2ccd_sync.sv
// two-flop synchroniser for one level
`default_nettype none
module i2ccd_sync
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b1;
      q <= 1'b1;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ===== bench/i2ccd_sva.sv
// checker: port-level properties of the collision block
`default_nettype none
module i2ccd_sva
  import i2ccd_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // register port
  input wire i2ccd_pkg::i2ccd_bus_t BUS,
  input wire logic [7:0] RDATA,
  // lines
  input wire i2ccd_pkg::i2ccd_lines_t LINES,
  input wire logic SCL_O,
  input wire logic SCL_OE_N,
  input wire logic SDA_O,
  input wire logic SDA_OE_N
);
  logic rd_q;
  logic [2:0] ra_q;
  always_ff @(posedge MCLK)
  begin
    rd_q <= BUS.rd;
    ra_q <= BUS.addr;
  end
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);
  a_pins_open_drain: assert property (!SCL_O && !SDA_O)
    else $error("line output value not zero");
  a_reset_release: assert property (!$past(RESETN) |-> SCL_OE_N && SDA_OE_N)
    else $error("lines driven right after reset");
  a_rdata_quiet: assert property (!rd_q |-> RDATA == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (rd_q && ra_q > OFF_FLAGS |-> RDATA == 8'h00)
    else $error("unmapped index not zero");
  a_con1_mask: assert property (rd_q && ra_q == OFF_CON1 |-> (RDATA & ~CON1_IMPL) == 8'h00)
    else $error("control one spare bits set");
  a_con2_mask: assert property (rd_q && ra_q == OFF_CON2 |-> (RDATA & ~CON2_IMPL) == 8'h00)
    else $error("control two spare bits set");
  a_stat_mask: assert property (rd_q && ra_q == OFF_STAT |-> (RDATA & ~STAT_IMPL) == 8'h00)
    else $error("status spare bits set");
  a_flags_mask: assert property (rd_q && ra_q == OFF_FLAGS |-> (RDATA & ~FLAGS_IMPL) == 8'h00)
    else $error("flag spare bits set");
endmodule
bind i2ccd_top i2ccd_sva u_sva (.MCLK(MCLK), .RESETN(RESETN), .BUS(BUS),
  .RDATA(RDATA), .LINES(LINES), .SCL_O(SCL_O), .SCL_OE_N(SCL_OE_N),
  .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N));
`default_nettype wire

// ===== bench/i2ccd_bus_peer.sv
// other bus parties: wired-and lines with pull-ups
`default_nettype none
module i2ccd_bus_peer
  import i2ccd_pkg::*;
(
  // device enables
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  // other master pulls low when set
  input wire logic pull_scl,
  input wire logic pull_sda,
  // resolved levels
  output wire i2ccd_pkg::i2ccd_lines_t lines
);
  timeunit 1ns;
  timeprecision 100ps;
  assign lines.scl_in = scl_oe_n & ~pull_scl;
  assign lines.sda_in = sda_oe_n & ~pull_sda;
endmodule
`default_nettype wire

// ===== bench/i2ccd_tb_top.sv
// testbench: registers, repeated start, stop and collisions
`default_nettype none
module i2ccd_tb_top
  import i2ccd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, resetn, scl_o, scl_oe_n, sda_o, sda_oe_n, pull_scl, pull_sda;
  i2ccd_bus_t bus;
  i2ccd_lines_t lines;
  logic [7:0] rdata, v;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  // address, write data, expected read back
  localparam logic [18:0] ROWS [7] = '{{OFF_BUF, 8'h5A, 8'h5A},
    {OFF_ADD, 8'h83, 8'h83}, {OFF_CON1, 8'hFF, 8'h3F},
    {OFF_CON2, 8'hE8, 8'h00}, {OFF_STAT, 8'hFF, 8'h00},
    {OFF_FLAGS, 8'hFF, 8'h00}, {3'h6, 8'hFF, 8'h00}};
  i2ccd_top DUT (.MCLK(mclk), .RESETN(resetn), .BUS(bus), .RDATA(rdata),
    .LINES(lines), .SCL_O(scl_o), .SCL_OE_N(scl_oe_n), .SDA_O(sda_o),
    .SDA_OE_N(sda_oe_n));
  i2ccd_bus_peer u_peer (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
    .pull_scl(pull_scl), .pull_sda(pull_sda), .lines(lines));
  task automatic close_out;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
      err_total++;
    if (got !== exp)
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge mclk);
  endtask
  // poll flags, check them and the enables, then clear the flags
  task automatic settle(input logic [7:0] flag);
    v = 8'h00;
    for (int i = 0; i < 300 && v === 8'h00; i++)
      rd(OFF_FLAGS, v);
    chk(v, flag);
    rd(OFF_CON2, v);
    chk(v, 8'h00);
    wr(OFF_FLAGS, 8'h03);
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      close_out;
    end
  end
  initial
  begin
    resetn = 1'b0;
    bus = '0;
    pull_scl = 1'b0;
    pull_sda = 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    for (int a = 0; a < 8; a++)
    begin
      rd(a[2:0], v);
      chk(v, 8'h00);
    end
    foreach (ROWS[i])
    begin
      wr(ROWS[i][18:16], ROWS[i][15:8]);
      rd(ROWS[i][18:16], v);
      chk(v, ROWS[i][7:0]);
    end
    wr(OFF_ADD, 8'h07);
    wr(OFF_CON1, 8'h20);
    wr(OFF_CON2, 8'h02);
    settle(8'h01);
    chk({6'h00, scl_oe_n, sda_oe_n}, 8'h00);
    rd(OFF_STAT, v);
    chk(v & 8'h08, 8'h08);
    wr(OFF_CON2, 8'h02);
    @(posedge scl_oe_n);
    repeat (5) @(posedge mclk);
    pull_sda <= 1'b1;
    settle(8'h01);
    pull_sda <= 1'b0;
    wr(OFF_CON2, 8'h04);
    settle(8'h01);
    chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    rd(OFF_STAT, v);
    chk(v & 8'h10, 8'h10);
    wr(OFF_CON2, 8'h02);
    @(posedge scl_oe_n);
    pull_sda <= 1'b1;
    settle(8'h02);
    chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    pull_sda <= 1'b0;
    wr(OFF_CON2, 8'h02);
    @(posedge scl_oe_n);
    repeat (4) @(posedge mclk);
    pull_scl <= 1'b1;
    settle(8'h02);
    pull_scl <= 1'b0;
    pull_sda <= 1'b1;
    wr(OFF_CON2, 8'h04);
    settle(8'h02);
    pull_sda <= 1'b0;
    wr(OFF_CON2, 8'h04);
    @(posedge scl_oe_n);
    repeat (3) @(posedge mclk);
    pull_scl <= 1'b1;
    settle(8'h02);
    pull_scl <= 1'b0;
    close_out;
  end
endmodule
`default_nettype wire
